// File: sbpm_port.sv
// top of the six-bit port with pin multiplexing
// assumes a same-clock register master and asynchronous pins
`include "sbpm_map.svh"
`timescale 1ns/10ps
module sbpm_port
    import sbpm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    input wire logic xdma_ack_ch2,
    input wire logic xdma_ack_ch3,
    input wire logic xdma_end_ch2,
    input wire logic xdma_end_ch3,
    input wire logic [3:0] irq_pin_select_reg,
    output logic int_req2,
    output logic int_req3,
    output logic int_req4,
    output logic int_req5,
    input wire logic prev_pin_in,
    output logic prev_pin_out,
    output logic prev_pin_oe,
    output logic dma_req0,
    output logic xdma_req0
);
    ////////////////////////////////////////////////////////////////
    sbpm_pins_if pins ();
    sbpm_bits_t dir_q;
    sbpm_bits_t out_q;
    sbpm_byte_t cfg_q;
    logic [1:0] prev_q;
    logic prev_s_meta_q;
    logic prev_s_q;
    sbpm_bits_t alt_en;
    sbpm_bits_t alt_val;
    sbpm_byte_t rdata_d;
    logic exp_mode;
    logic dir_we;
    logic out_we;
    logic cfg_we;
    logic prev_we;
    sbpm_bits_t gpio_out;
    sbpm_bits_t irq_mask;
    sbpm_bits_t irq_src;
    logic prev_dir;
    logic prev_val;

    sbpm_pads u_pads (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(pin_in),
        .pins(pins)
    );
    assign pins.dir = dir_q;
    assign pins.dout = out_q;

    // pin-state view: latch where the direction bit is set, pin elsewhere
    function automatic sbpm_bits_t pin_view(input sbpm_bits_t d, input sbpm_bits_t o, input sbpm_bits_t s);
        pin_view = (d & o) | (~d & s);
    endfunction

    ////////////////////////////////////////////////////////////////
    // one compare shared by every stored register
    function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] idx);
        wr_hit = wr && (addr == idx);
    endfunction

    // the pin-state index has no strobe, so nothing stored can change there
    assign dir_we = wr_hit(reg_wr, reg_addr, `SBPM_OFF_DIR);
    assign out_we = wr_hit(reg_wr, reg_addr, `SBPM_OFF_OUT);
    assign cfg_we = wr_hit(reg_wr, reg_addr, `SBPM_OFF_CFG);
    assign prev_we = wr_hit(reg_wr, reg_addr, `SBPM_OFF_PREV);

    ////////////////////////////////////////////////////////////////
    // direction register; only six bits stored so 7:6 cannot be set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dir_q <= `SBPM_RST_DIR;
        end else if (dir_we) begin
            dir_q <= reg_wdata[5:0];
        end
    end

    // output latch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_q <= `SBPM_RST_OUT;
        end else if (out_we) begin
            out_q <= reg_wdata[5:0];
        end
    end

    // mode and alternate-function control bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_q <= `SBPM_RST_CFG;
        end else if (cfg_we) begin
            cfg_q <= reg_wdata;
        end
    end

    // previous port pin 0: bit 0 direction, bit 1 output value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_q <= 2'h0;
        end else if (prev_we) begin
            prev_q <= reg_wdata[1:0];
        end
    end

    // pin of the neighbouring port is asynchronous too
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_s_meta_q <= 1'b0;
            prev_s_q <= 1'b0;
        end else begin
            prev_s_meta_q <= prev_pin_in;
            prev_s_q <= prev_s_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // alternate functions exist only in expanded modes
    assign exp_mode = cfg_q[`SBPM_CFG_EXP];

    // one owner per pin; outside expanded modes every pin stays plain I/O
    always_comb begin
        alt_en = 6'h00;
        alt_val = 6'h00;
        // pin 5 gives up its direction bit to the channel 3 acknowledge
        if (exp_mode && cfg_q[`SBPM_CFG_ACK3]) begin
            alt_en[5] = 1'b1;
            alt_val[5] = xdma_ack_ch3;
        end
        // pin 4 does the same for the channel 2 acknowledge
        if (exp_mode && cfg_q[`SBPM_CFG_ACK2]) begin
            alt_en[4] = 1'b1;
            alt_val[4] = xdma_ack_ch2;
        end
        // pin 3 carries the channel 3 transfer end
        if (exp_mode && cfg_q[`SBPM_CFG_END3]) begin
            alt_en[3] = 1'b1;
            alt_val[3] = xdma_end_ch3;
        end
        // pin 2 carries the channel 2 transfer end
        if (exp_mode && cfg_q[`SBPM_CFG_END2]) begin
            alt_en[2] = 1'b1;
            alt_val[2] = xdma_end_ch2;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one pin's drive: the alternate source wins over the plain latch
    function automatic logic pin_drive(input logic alt_on, input logic alt_bit, input logic plain);
        pin_drive = alt_on ? alt_bit : plain;
    endfunction

    // latch value only reaches a pin set as output
    assign gpio_out = dir_q & out_q;

    // alternate function overrides direction; pins 1 and 0 never have one
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_oe[i] = alt_en[i] | dir_q[i];
            pin_out[i] = pin_drive(alt_en[i], alt_val[i], gpio_out[i]);
        end
    end

    ////////////////////////////////////////////////////////////////
    // select bits line up with pins 5 to 2; pins 1 and 0 raise nothing here
    assign irq_mask = {irq_pin_select_reg, 2'h0};

    // routing runs alongside any pin function, so a driven pin can still interrupt
    assign irq_src = irq_mask & pins.sync;
    assign int_req2 = irq_src[2];
    assign int_req3 = irq_src[3];
    assign int_req4 = irq_src[4];
    assign int_req5 = irq_src[5];

    ////////////////////////////////////////////////////////////////
    // neighbouring pin 0: bit 0 direction, bit 1 output value
    assign prev_dir = prev_q[0];
    assign prev_val = prev_q[1];

    // plain I/O only; the latch shows just while set as output
    assign prev_pin_oe = prev_dir;
    assign prev_pin_out = prev_dir & prev_val;

    // both request inputs follow the synchronised level, one of them gated
    assign xdma_req0 = prev_s_q;
    assign dma_req0 = cfg_q[`SBPM_CFG_DSEL] & prev_s_q;

    ////////////////////////////////////////////////////////////////
    // widen a six-bit view to a bus byte with the given top bits
    function automatic sbpm_byte_t to_byte(input logic [1:0] hi, input sbpm_bits_t v);
        to_byte = {hi, v};
    endfunction

    // read mux; pin-state writes fall through with no decode
    always_comb begin
        unique case (reg_addr)
            `SBPM_OFF_DIR: rdata_d = `SBPM_DIR_READ;
            `SBPM_OFF_OUT: rdata_d = to_byte(2'h0, out_q);
            `SBPM_OFF_PIN: rdata_d = to_byte(`SBPM_PIN_HI, pin_view(pins.dir, pins.dout, pins.sync));
            `SBPM_OFF_CFG: rdata_d = cfg_q;
            `SBPM_OFF_PREV: rdata_d = {6'h00, prev_q};
            default: rdata_d = `SBPM_UNMAPPED;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// File: sbpm_map.svh
// constants for the six-bit port with pin multiplexing
// assumes a plain register port with one-cycle read latency
`ifndef SBPM_MAP_SVH
`define SBPM_MAP_SVH
`define SBPM_ADDR_W 4
`define SBPM_OFF_DIR 4'h0
`define SBPM_OFF_OUT 4'h1
`define SBPM_OFF_PIN 4'h2
`define SBPM_OFF_CFG 4'h3
`define SBPM_OFF_PREV 4'h4
`define SBPM_RST_DIR 6'h00
`define SBPM_RST_OUT 6'h00
`define SBPM_RST_CFG 8'h00
`define SBPM_DIR_READ 8'h00
`define SBPM_PIN_HI 2'h0
`define SBPM_UNMAPPED 8'h00
`define SBPM_CFG_EXP 0
`define SBPM_CFG_ACK2 1
`define SBPM_CFG_ACK3 2
`define SBPM_CFG_END2 3
`define SBPM_CFG_END3 4
`define SBPM_CFG_DSEL 5
`endif

// File: sbpm_pkg.sv
// types shared by the port modules
package sbpm_pkg;
    typedef logic [5:0] sbpm_bits_t;
    typedef logic [7:0] sbpm_byte_t;
endpackage

// File: sbpm_pins_if.sv
// pin control bundle between the port core and its pad logic
`timescale 1ns/10ps
interface sbpm_pins_if;
    import sbpm_pkg::*;
    sbpm_bits_t dir;
    sbpm_bits_t dout;
    sbpm_bits_t sync;
    modport core (output dir, output dout, input sync);
    modport pads (input dir, input dout, output sync);
endinterface

// File: sbpm_sync.sv
// two-flop synchroniser for a pin vector
// assumes asynchronous pin levels
`timescale 1ns/10ps
module sbpm_sync #(
    parameter int W = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    // first stage is read only by the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: sbpm_pads.sv
// pad-side view: synchronises the port pins for the core
// assumes pins are sampled asynchronously
`timescale 1ns/10ps
module sbpm_pads (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [5:0] pin_in,
    sbpm_pins_if.pads pins
);
    sbpm_sync #(.W(6)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pins.sync)
    );
endmodule

// File: sbpm_port_props.sv
// checker for the six-bit port, on its top-level ports only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module sbpm_port_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [3:0] irq_pin_select_reg,
    input wire logic int_req2,
    input wire logic dma_req0,
    input wire logic xdma_req0
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // pins 1 and 0 have no alternate use, so they show the registers bare
    sequence s_dir_wr; reg_wr && reg_addr == 4'h0; endsequence
    sequence s_out_wr; reg_wr && reg_addr == 4'h1; endsequence
    AST_DIR_RD: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == 8'h00) else $error("dir read");
    AST_OE_WR: assert property (s_dir_wr |=> pin_oe[1:0] == $past(reg_wdata[1:0])) else $error("dir write");
    AST_OUT_WR: assert property (s_out_wr ##1 pin_oe[1:0] == 2'h3 |-> pin_out[1:0] == $past(reg_wdata[1:0]))
        else $error("out write");
    AST_HI_BITS: assert property (reg_rd && reg_addr < 4'h3 |=> reg_rdata[7:6] == 2'h0) else $error("high bits");
    AST_PIN_RD: assert property (reg_rd && reg_addr == 4'h2 && pin_oe[0] |=> reg_rdata[0] == $past(pin_out[0]))
        else $error("pin read");
    AST_RD_IDLE: assert property (reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("stray read data");
    AST_IRQ_OFF: assert property (!irq_pin_select_reg[0] && !$past(irq_pin_select_reg[0]) |-> !int_req2)
        else $error("irq not gated");
    AST_REQ_GATE: assert property (dma_req0 |-> xdma_req0) else $error("request gate");
    AST_RST_OE: assert property ($past(rst) |-> pin_oe == 6'h00) else $error("reset drive");
endmodule

bind sbpm_port sbpm_port_props i_props (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq_pin_select_reg(irq_pin_select_reg), .int_req2(int_req2), .dma_req0(dma_req0), .xdma_req0(xdma_req0));

// File: sbpm_far_model.sv
// far-side pads: what the port reads back from its pins
// assumes the bench sets the outside level of undriven pins
`timescale 1ns/10ps
module sbpm_far_model (
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] ext_lvl,
    output logic [5:0] pin_in
);
    // a driven pin reads its own drive, others the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// File: test_six_bit_port_with_pin_mux.sv
// self-checking bench for the six-bit port
// assumes read data in the cycle after the read strobe
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("unexpected %0t %h %h", $time, a, e); end end
module test_six_bit_port_with_pin_mux;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, prev_pin_in = 1;
    logic [3:0] reg_addr = 4'h0, irq_sel = 4'hf, xd = 4'h5;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [5:0] pin_in, pin_out, pin_oe, ext_lvl = 6'h00;
    logic int_req2, int_req3, int_req4, int_req5, prev_pin_out, prev_pin_oe, dma_req0, xdma_req0;
    int fails = 0, total_checks = 0;
    sbpm_port i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .xdma_ack_ch2(xd[0]), .xdma_ack_ch3(xd[1]), .xdma_end_ch2(xd[2]), .xdma_end_ch3(xd[3]),
        .irq_pin_select_reg(irq_sel), .int_req2(int_req2), .int_req3(int_req3), .int_req4(int_req4),
        .int_req5(int_req5), .prev_pin_in(prev_pin_in), .prev_pin_out(prev_pin_out), .prev_pin_oe(prev_pin_oe),
        .dma_req0(dma_req0), .xdma_req0(xdma_req0));
    sbpm_far_model i_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
    ////////////////////////////////////////
    // 100 MHz clock
    initial forever #5 clk_sys = ~clk_sys;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // pins pass two sync flops before they are visible
    task automatic settle(input logic [5:0] lvl, input logic p);
        @(posedge clk_sys);
        ext_lvl <= lvl;
        prev_pin_in <= p;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence; a hang is cut by the watchdog below
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h1, 8'h00);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hff);
        `CHK(pin_oe, 6'h3f)
        wr(4'h1, 8'hd5);
        `CHK(pin_out, 6'h15)
        rd(4'h1, 8'h15);
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h15);
        wr(4'h2, 8'h3f);
        rd(4'h1, 8'h15);
        rd(4'h2, 8'h15);
        rd(4'hf, 8'h00);
        wr(4'h0, 8'h00);
        settle(6'h2a, 1'b1);
        rd(4'h2, 8'h2a);
        `CHK({int_req5, int_req4, int_req3, int_req2}, 4'ha)
        // drop every select but pin 3's
        @(posedge clk_sys);
        irq_sel <= 4'h2;
        @(posedge clk_sys);
        #1;
        `CHK({int_req5, int_req4, int_req3, int_req2}, 4'h2)
        wr(4'h3, 8'h01);
        `CHK(pin_oe, 6'h00)
        wr(4'h3, 8'h03);
        `CHK({pin_oe, pin_out}, 12'h410)
        wr(4'h3, 8'h1f);
        `CHK(pin_oe, 6'h3c)
        `CHK(pin_out[5:2], 4'h5)
        wr(4'h3, 8'h1e);
        `CHK(pin_oe, 6'h00)
        rd(4'h3, 8'h1e);
        wr(4'h4, 8'h03);
        rd(4'h4, 8'h03);
        wr(4'h3, 8'h20);
        `CHK({prev_pin_oe, prev_pin_out, dma_req0, xdma_req0}, 4'hf)
        settle(6'h2a, 1'b0);
        `CHK({dma_req0, xdma_req0}, 2'h0)
        wr(4'h3, 8'h00);
        settle(6'h2a, 1'b1);
        `CHK({dma_req0, xdma_req0}, 2'h1)
        close_out;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        close_out;
    end
endmodule
